// ### async_timer.sv
/*
  Asynchronous clocking support of an 8-bit timer: holding registers, busy
  flags, flag synchronisation, wake-up, prescaler and synchronisation mode.
  Assumes the processor clock runs over four times the oscillator rate and
  that the oscillator input is a level sampled on ref_clk.
*/
// Notes on behaviour
// - Writes land in a holding register, committed after two oscillator edges.
// - Counter, compare and control each own a separate holding register.
// - Compare match is suppressed while counter or compare write pends.
// - Interrupt logic needs one oscillator cycle to rearm after wake-up.
// - Oscillator runs in all sleep states except the deepest ones.
// - Timer contents are undefined after waking from deepest sleep.
// - Timer interrupt in light sleep starts wake-up on next timer cycle.
// - After timer wake-up the processor stalls four cycles.
// - Async counter reads use a copy refreshed on each oscillator rising edge outside sleep.
// - Flag synchronisation takes three processor cycles plus one timer cycle.
// - Compare output changes on the timer clock, not the processor clock.
// - Mask bit 1 enables compare, bit 0 overflow; both gated globally.
// - Compare flag sets on match; cleared by vector or writing one.
// - Overflow flag sets on overflow, or at bottom turnaround in phase PWM.
// - Default source is processor clock; async select uses oscillator pin.
// - Prescaler gives 1, 8, 32, 64, 128, 256, 1024 and stop; resettable.
// - Sync hold mode keeps prescaler resets; clearing it releases them.
// - Busy flags set on write in async mode, clear on commit.
// - Compare and control reads return holding value; counter reads timer.
// - Prescaler reset self-clears, in async after reset occurs, never in hold.
`default_nettype none
module async_timer
  import timer_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic osc_in_pin,
  input wire logic global_irq_enable,
  input wire logic ack_compare,
  input wire logic ack_overflow,
  input wire logic sleep_light,
  input wire logic sleep_deep,
  output logic irq_compare,
  output logic irq_overflow,
  output logic wake_request,
  output logic cpu_stall,
  output logic compare_output_pin,
  output logic osc_enable,
  output logic osc_pins_detached,
  output logic prescaler_reset_others
);

  logic osc_s1, osc_s2, osc_s3;
  logic osc_edge;
  logic async_clock_select;
  logic [2:0] wr_reg;
  logic [7:0] hold [3];
  logic [2:0] busy;
  logic [2:0] seen;
  logic [2:0] commit;
  logic [7:0] count_value, compare_value, timer_control, count_copy;
  logic [7:0] timer_interrupt_enable;
  logic [1:0] flags;
  logic sync_hold_mode, prescaler_reset_t0;
  logic [PSC_W-1:0] psc;
  logic src_tick, tick, match, load_cnt, blk, dir_down;
  logic [1:0] mode, com;
  logic [7:0] top;
  logic ev_cmp, ev_ovf;
  logic [1:0] pend, inject, delivered;
  logic [1:0] fsync [FLAG_SYNC_CYCLES];
  logic armed;
  logic [2:0] stall_cnt;

  function automatic logic div_hit(input logic [2:0] cs, input logic [PSC_W-1:0] p);
    case (cs)
      3'h1: div_hit = 1'b1;
      3'h2: div_hit = &p[2:0];
      3'h3: div_hit = &p[4:0];
      3'h4: div_hit = &p[5:0];
      3'h5: div_hit = &p[6:0];
      3'h6: div_hit = &p[7:0];
      3'h7: div_hit = &p[9:0];
      default: div_hit = 1'b0;
    endcase
  endfunction : div_hit

  // Oscillator pin synchroniser; the second and third stages feed edge logic
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      osc_s1 <= 1'b0;
      osc_s2 <= 1'b0;
      osc_s3 <= 1'b0;
    end else begin
      osc_s1 <= osc_in_pin;
      osc_s2 <= osc_s1;
      osc_s3 <= osc_s2;
    end
  end

  assign osc_edge = osc_s2 & ~osc_s3 & osc_enable;
  assign src_tick = async_clock_select ? osc_edge : 1'b1;

  always_comb begin
    wr_reg = 3'h0;
    wr_reg[H_COUNT] = wr && addr == A_COUNT;
    wr_reg[H_COMPARE] = wr && addr == A_COMPARE;
    wr_reg[H_CONTROL] = wr && addr == A_CONTROL;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      async_clock_select <= 1'b0;
      osc_enable <= 1'b0;
      osc_pins_detached <= 1'b0;
    end else begin
      if (wr && addr == A_ASYNC) begin
        async_clock_select <= wdata[ASYNC_SEL_BIT];
      end
      osc_enable <= async_clock_select && !sleep_deep;
      osc_pins_detached <= async_clock_select;
    end
  end

  // Holding registers, one per destination, each with its own busy flag
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < 3; i++) begin
      if (reset) begin
        hold[i] <= REG_RESET;
        busy[i] <= 1'b0;
        seen[i] <= 1'b0;
      end else if (wr_reg[i]) begin
        hold[i] <= wdata;
        busy[i] <= async_clock_select;
        seen[i] <= 1'b0;
      end else if (busy[i] && osc_edge) begin
        seen[i] <= 1'b1;
        if (seen[i]) begin
          busy[i] <= 1'b0;
        end
      end
    end
  end

  assign commit = busy & seen & {3{osc_edge}};

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      compare_value <= REG_RESET;
      timer_control <= REG_RESET;
    end else begin
      if (!async_clock_select && wr_reg[H_COMPARE]) begin
        compare_value <= wdata;
      end else if (commit[H_COMPARE]) begin
        compare_value <= hold[H_COMPARE];
      end
      if (!async_clock_select && wr_reg[H_CONTROL]) begin
        timer_control <= wdata;
      end else if (commit[H_CONTROL]) begin
        timer_control <= hold[H_CONTROL];
      end
    end
  end

  // Special function register: sync hold mode and prescaler resets
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sync_hold_mode <= 1'b0;
      prescaler_reset_t0 <= 1'b0;
      prescaler_reset_others <= 1'b0;
    end else if (wr && addr == A_SPECIAL) begin
      sync_hold_mode <= wdata[SYNC_HOLD_BIT];
      prescaler_reset_t0 <= wdata[PSR_T0_BIT];
      prescaler_reset_others <= wdata[PSR_OTHERS_BIT];
    end else if (!sync_hold_mode) begin
      prescaler_reset_others <= 1'b0;
      if (src_tick) begin
        prescaler_reset_t0 <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      psc <= '0;
    end else if (src_tick) begin
      psc <= prescaler_reset_t0 ? '0 : psc + 1'b1;
    end
  end

  assign tick = src_tick && !prescaler_reset_t0
              && div_hit(timer_control[2:0], psc);
  assign mode = {timer_control[WGM1_BIT], timer_control[WGM0_BIT]};
  assign com = timer_control[COM_LSB+1:COM_LSB];
  assign top = (mode == MODE_CTC) ? compare_value : COUNT_MAX;
  assign load_cnt = async_clock_select ? commit[H_COUNT] : wr_reg[H_COUNT];
  assign match = count_value == compare_value && !blk
               && !busy[H_COMPARE] && !busy[H_COUNT];

  // Counter, compare output and raw events, all advanced by the timer tick
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      count_value <= REG_RESET;
      dir_down <= 1'b0;
      blk <= 1'b0;
      compare_output_pin <= 1'b0;
      ev_cmp <= 1'b0;
      ev_ovf <= 1'b0;
    end else begin
      ev_cmp <= 1'b0;
      ev_ovf <= 1'b0;
      if (load_cnt) begin
        count_value <= async_clock_select ? hold[H_COUNT] : wdata;
        blk <= 1'b1;
      end else if (tick) begin
        blk <= 1'b0;
        ev_cmp <= match;
        if (mode == MODE_PHASE) begin
          if (!dir_down && count_value == COUNT_MAX) begin
            dir_down <= 1'b1;
            count_value <= count_value - 1'b1;
          end else if (dir_down && count_value == COUNT_BOTTOM) begin
            dir_down <= 1'b0;
            ev_ovf <= 1'b1;
            count_value <= count_value + 1'b1;
          end else begin
            count_value <= dir_down ? count_value - 1'b1 : count_value + 1'b1;
          end
          if (match && com[1]) begin
            compare_output_pin <= com[0] ^ dir_down;
          end
        end else begin
          ev_ovf <= count_value == COUNT_MAX;
          count_value <= (count_value == top) ? COUNT_BOTTOM : count_value + 1'b1;
          if (mode == MODE_FAST) begin
            if (com[1] && match) begin
              compare_output_pin <= com[0];
            end else if (com[1] && count_value == top) begin
              compare_output_pin <= !com[0];
            end
          end else if (match) begin
            case (com)
              2'h1: compare_output_pin <= !compare_output_pin;
              2'h2: compare_output_pin <= 1'b0;
              2'h3: compare_output_pin <= 1'b1;
              default: compare_output_pin <= compare_output_pin;
            endcase
          end
        end
      end
    end
  end

  // Events wait one timer cycle, then three processor cycles, before flagging
  assign inject = async_clock_select ? (osc_edge ? pend : 2'h0) : {ev_cmp, ev_ovf};
  assign delivered = fsync[FLAG_SYNC_CYCLES-1];

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pend <= 2'h0;
      for (int i = 0; i < FLAG_SYNC_CYCLES; i++) begin
        fsync[i] <= 2'h0;
      end
    end else begin
      if (osc_edge || !async_clock_select) begin
        pend <= {ev_cmp, ev_ovf};
      end else begin
        pend <= pend | {ev_cmp, ev_ovf};
      end
      fsync[0] <= inject;
      for (int i = 1; i < FLAG_SYNC_CYCLES; i++) begin
        fsync[i] <= fsync[i-1];
      end
    end
  end

  // Flags: a hardware set wins over a clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      flags <= 2'h0;
    end else begin
      flags[CMP_BIT] <= delivered[CMP_BIT] || (flags[CMP_BIT] && !ack_compare
        && !(wr && addr == A_IRQ_FLAGS && wdata[CMP_BIT]));
      flags[OVF_BIT] <= delivered[OVF_BIT] || (flags[OVF_BIT] && !ack_overflow
        && !(wr && addr == A_IRQ_FLAGS && wdata[OVF_BIT]));
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      timer_interrupt_enable <= REG_RESET;
      irq_compare <= 1'b0;
      irq_overflow <= 1'b0;
    end else begin
      if (wr && addr == A_IRQ_EN) begin
        timer_interrupt_enable <= wdata;
      end
      irq_compare <= flags[CMP_BIT] && timer_interrupt_enable[CMP_BIT]
                  && global_irq_enable;
      irq_overflow <= flags[OVF_BIT] && timer_interrupt_enable[OVF_BIT]
                   && global_irq_enable;
    end
  end

  // Wake-up from light sleep, rearm after one oscillator cycle, then stall
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wake_request <= 1'b0;
      armed <= 1'b1;
      stall_cnt <= 3'h0;
      cpu_stall <= 1'b0;
    end else begin
      wake_request <= sleep_light && armed && !wake_request
                   && |(delivered & timer_interrupt_enable[1:0]);
      if (wake_request) begin
        armed <= 1'b0;
      end else if (osc_edge) begin
        armed <= 1'b1;
      end
      if (wake_request) begin
        stall_cnt <= STALL_CYCLES;
        cpu_stall <= 1'b1;
      end else if (stall_cnt > 3'h1) begin
        stall_cnt <= stall_cnt - 1'b1;
      end else begin
        stall_cnt <= 3'h0;
        cpu_stall <= 1'b0;
      end
    end
  end

  // Counter copy seen by the processor; frozen while its clock sleeps
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      count_copy <= REG_RESET;
    end else if (osc_edge && !sleep_light && !sleep_deep) begin
      count_copy <= count_value;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rdata <= 8'h00;
    end else if (rd) begin
      case (addr)
        A_COUNT: rdata <= async_clock_select ? count_copy : count_value;
        A_COMPARE: rdata <= hold[H_COMPARE];
        A_CONTROL: rdata <= hold[H_CONTROL];
        A_ASYNC: rdata <= {4'h0, async_clock_select, busy};
        A_IRQ_EN: rdata <= timer_interrupt_enable;
        A_IRQ_FLAGS: rdata <= {6'h00, flags};
        A_SPECIAL: rdata <= {sync_hold_mode, 5'h00, prescaler_reset_t0,
                             prescaler_reset_others};
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  busy_on_write_a: assert property (wr_reg[H_COUNT] && async_clock_select
    |=> busy[H_COUNT]) else $error("count busy not set");
  commit_edge_a: assert property ($fell(busy[H_COMPARE]) && !$past(wr_reg[H_COMPARE])
    |-> $past(osc_edge) && $past(seen[H_COMPARE])) else $error("early commit");
  hold_separate_a: assert property (busy[H_COMPARE] && wr_reg[H_COUNT] && !osc_edge
    |=> busy[H_COMPARE]) else $error("compare transfer disturbed");
  match_block_a: assert property (busy[H_COMPARE] || busy[H_COUNT]
    |=> !ev_cmp) else $error("match while pending");
  flag_sync_a: assert property (async_clock_select && osc_edge && pend[CMP_BIT]
    && !flags[CMP_BIT] |-> ##4 flags[CMP_BIT]) else $error("flag sync delay wrong");
  stall_len_a: assert property (wake_request |=> cpu_stall [*4] ##1 !cpu_stall)
    else $error("stall length wrong");
  rearm_a: assert property (wake_request |=> !wake_request [*2])
    else $error("wake repeated without rearm");
  osc_stop_a: assert property (sleep_deep |=> !osc_enable)
    else $error("oscillator runs in deep sleep");
  irq_gate_a: assert property (flags[CMP_BIT] && timer_interrupt_enable[CMP_BIT]
    && global_irq_enable |=> irq_compare) else $error("compare irq missing");
  psr_hold_a: assert property (sync_hold_mode && prescaler_reset_t0 && !wr
    |=> prescaler_reset_t0) else $error("prescaler reset cleared in hold");
  copy_stable_a: assert property (async_clock_select && !osc_edge
    |=> $stable(count_copy)) else $error("copy moved off edge");

  async_commit_c: cover property (busy[H_COUNT] ##[1:300] !busy[H_COUNT]);
  wake_c: cover property (wake_request ##1 cpu_stall);
  match_flag_c: cover property (ev_cmp ##[1:300] flags[CMP_BIT]);

endmodule : async_timer
`default_nettype wire

// ### osc_model.sv
/*
  Stand-in for the watch crystal on the oscillator input pin.
  Assumes it is stepped by the bench clock and held still while run is low.
*/
`default_nettype none
module osc_model #(
  parameter int HALF = 8
) (
  input wire logic clk,
  input wire logic run,
  output logic osc
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  initial begin
    osc = 1'b0;
    cnt = 0;
  end
  // A period of 2*HALF bench cycles keeps the core clock over four times faster
  // No edges at all while the device has the oscillator stopped
  always @(posedge clk) begin
    if (run) begin
      if (cnt == HALF - 1) begin
        cnt <= 0;
        osc <= ~osc;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule : osc_model
`default_nettype wire

// ### test_async_timer_clock_crossing.sv
/*
  Self-checking bench for the asynchronous timer: register bus, holding
  transfers, flags, wake-up and prescaler control. Assumes timer_pkg and
  the oscillator stand-in are compiled first.
*/
`default_nettype none
module test_async_timer_clock_crossing
  import timer_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] v; string nm;} note_t;
  localparam int LIMIT = 20000;
  logic ref_clk, reset, wr, rd, osc, gie, ack_c, ack_o, sl, sd, osc_d, rd_seen;
  logic [ADDR_W-1:0] addr;
  logic [7:0] wdata, rdata;
  logic irq_c, irq_o, wake, stall, cmp_pin, osc_en, detached, psr_o;
  int fail_count = 0;
  int n_tests = 0;
  int cycles = 0;
  int rises = 0;
  int wakes = 0;
  int stall_cnt = 0;
  int seed = 32'h9b40;
  note_t q[$];

  async_timer async_timer_inst (.ref_clk(ref_clk), .reset(reset), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .osc_in_pin(osc),
    .global_irq_enable(gie), .ack_compare(ack_c), .ack_overflow(ack_o),
    .sleep_light(sl), .sleep_deep(sd), .irq_compare(irq_c), .irq_overflow(irq_o),
    .wake_request(wake), .cpu_stall(stall), .compare_output_pin(cmp_pin),
    .osc_enable(osc_en), .osc_pins_detached(detached),
    .prescaler_reset_others(psr_o));
  osc_model #(.HALF(8)) osc_model_inst (.clk(ref_clk), .run(osc_en), .osc(osc));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize

  task automatic check_bit(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %b seen %b", nm, e, g);
    end
  endtask : check_bit

  task automatic check_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : check_byte

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask : wr_reg

  // Notes the expected byte; the watcher compares it in the answer cycle
  task automatic rd_reg(input logic [2:0] a, input logic [7:0] e, input string nm);
    note_t n;
    n.v = e;
    n.nm = nm;
    q.push_back(n);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    @(negedge ref_clk);
  endtask : rd_reg

  // Polls the status register until all three transfers have landed
  task automatic wait_idle(input int mark, input string nm);
    int i;
    for (i = 0; i < 300; i++) begin
      @(posedge ref_clk);
      addr <= A_ASYNC;
      rd <= 1'b1;
      @(posedge ref_clk);
      rd <= 1'b0;
      @(negedge ref_clk);
      if (rdata[2:0] === 3'h0) break;
    end
    check_bit({nm, " idle"}, 1'b1, i < 300);
    check_bit({nm, " two osc edges"}, 1'b1, rises - mark >= 2);
  endtask : wait_idle

  task automatic end_test(input string nm);
    $display("test %s finished", nm);
  endtask : end_test

  always @(posedge ref_clk) begin
    rd_seen <= rd;
    osc_d <= osc;
    if (osc && !osc_d) rises <= rises + 1;
    if (wake === 1'b1) begin
      wakes <= wakes + 1;
      stall_cnt <= 0;
    end else if (stall === 1'b1) begin
      stall_cnt <= stall_cnt + 1;
    end
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      fail_count++;
      summarize();
    end
  end

  always @(negedge ref_clk) begin
    note_t n;
    if (rd_seen === 1'b1 && q.size() > 0) begin
      n = q.pop_front();
      check_byte(n.nm, n.v, rdata);
    end
  end

  initial begin
    int i;
    int mark;
    logic [7:0] v;
    {wr, rd, gie, ack_c, ack_o, sl, sd, osc_d, rd_seen} = '0;
    addr = '0;
    wdata = '0;
    reset = 1'b1;
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    rd_reg(A_IRQ_EN, REG_RESET, "irq enable reset");
    rd_reg(A_ASYNC, REG_RESET, "status reset");
    rd_reg(3'h7, 8'h00, "unmapped read");
    check_bit("pins attached", 1'b0, detached);
    end_test("reset");
    v = 8'($random(seed));
    wr_reg(A_COMPARE, v);
    wr_reg(A_CONTROL, 8'h00);
    wr_reg(A_COUNT, 8'h33);
    rd_reg(A_COMPARE, v, "sync compare");
    rd_reg(A_ASYNC, 8'h00, "sync never busy");
    repeat (20) @(posedge ref_clk);
    rd_reg(A_COUNT, 8'h33, "stopped count");
    end_test("sync");
    wr_reg(A_SPECIAL, 8'h02);
    repeat (2) @(posedge ref_clk);
    rd_reg(A_SPECIAL, 8'h00, "psr self clear");
    wr_reg(A_SPECIAL, 8'h83);
    repeat (4) @(posedge ref_clk);
    rd_reg(A_SPECIAL, 8'h83, "hold keeps resets");
    check_bit("others held", 1'b1, psr_o);
    wr_reg(A_SPECIAL, 8'h01);
    repeat (3) @(posedge ref_clk);
    rd_reg(A_SPECIAL, 8'h00, "hold release");
    check_bit("others released", 1'b0, psr_o);
    end_test("prescaler");
    wr_reg(A_IRQ_EN, 8'h00);
    wr_reg(A_ASYNC, 8'h08);
    repeat (2) @(posedge ref_clk);
    check_bit("pins detached", 1'b1, detached);
    check_bit("osc running", 1'b1, osc_en);
    v = (8'($random(seed)) & 8'h3f) | 8'h40;
    wr_reg(A_COMPARE, v);
    mark = rises;
    wr_reg(A_CONTROL, 8'h01);
    wr_reg(A_COUNT, 8'hfd);
    rd_reg(A_ASYNC, 8'h0f, "all busy");
    rd_reg(A_COMPARE, v, "compare holding");
    rd_reg(A_CONTROL, 8'h01, "control holding");
    wait_idle(mark, "async write");
    wr_reg(A_IRQ_FLAGS, 8'h03);
    gie <= 1'b1;
    sl <= 1'b1;
    wr_reg(A_IRQ_EN, 8'h03);
    end_test("async write");
    for (i = 0; i < 400 && irq_o !== 1'b1; i++) @(posedge ref_clk);
    check_bit("overflow irq", 1'b1, irq_o);
    repeat (10) @(posedge ref_clk);
    check_bit("one wake pulse", 1'b1, wakes == 1);
    check_bit("stall four", 1'b1, stall_cnt == 4);
    sl <= 1'b0;
    gie <= 1'b0;
    repeat (2) @(posedge ref_clk);
    check_bit("global gate", 1'b0, irq_o);
    rd_reg(A_IRQ_FLAGS, 8'h01, "overflow flag");
    ack_o <= 1'b1;
    @(posedge ref_clk);
    ack_o <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rd_reg(A_IRQ_FLAGS, 8'h00, "overflow acked");
    end_test("overflow wake");
    gie <= 1'b1;
    for (i = 0; i < 3000 && irq_c !== 1'b1; i++) @(posedge ref_clk);
    check_bit("compare irq", 1'b1, irq_c);
    check_bit("compare pin idle", 1'b0, cmp_pin);
    wr_reg(A_IRQ_FLAGS, 8'h02);
    repeat (2) @(posedge ref_clk);
    check_bit("compare cleared", 1'b0, irq_c);
    rd_reg(A_IRQ_FLAGS, 8'h00, "compare flag w1c");
    end_test("compare");
    sd <= 1'b1;
    repeat (3) @(posedge ref_clk);
    check_bit("osc stopped", 1'b0, osc_en);
    sd <= 1'b0;
    repeat (3) @(posedge ref_clk);
    check_bit("osc restarted", 1'b1, osc_en);
    end_test("deep sleep");
    summarize();
  end
endmodule : test_async_timer_clock_crossing
`default_nettype wire

// ### timer_pkg.sv
/*
  Constants for the asynchronous 8-bit timer: register offsets, bit positions,
  reset values and cycle counts. Assumes a single 25 MHz processor clock.
*/
`default_nettype none
package timer_pkg;
  localparam int ADDR_W = 3;
  localparam logic [2:0] A_COUNT = 3'h0;
  localparam logic [2:0] A_COMPARE = 3'h1;
  localparam logic [2:0] A_CONTROL = 3'h2;
  localparam logic [2:0] A_ASYNC = 3'h3;
  localparam logic [2:0] A_IRQ_EN = 3'h4;
  localparam logic [2:0] A_IRQ_FLAGS = 3'h5;
  localparam logic [2:0] A_SPECIAL = 3'h6;
  // Holding register index equals its busy bit position
  localparam int H_COUNT = 2;
  localparam int H_COMPARE = 1;
  localparam int H_CONTROL = 0;
  localparam int ASYNC_SEL_BIT = 3;
  localparam int CMP_BIT = 1;
  localparam int OVF_BIT = 0;
  localparam int SYNC_HOLD_BIT = 7;
  localparam int PSR_T0_BIT = 1;
  localparam int PSR_OTHERS_BIT = 0;
  localparam int WGM0_BIT = 6;
  localparam int WGM1_BIT = 3;
  localparam int COM_LSB = 4;
  localparam int PSC_W = 10;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hff;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_PHASE = 2'h1;
  localparam logic [1:0] MODE_CTC = 2'h2;
  localparam logic [1:0] MODE_FAST = 2'h3;
  localparam int FLAG_SYNC_CYCLES = 3;
  localparam logic [2:0] STALL_CYCLES = 3'h4;
endpackage : timer_pkg
`default_nettype wire
